// [common/spvl_defs.svh]
`ifndef SPVL_DEFS_SVH
`define SPVL_DEFS_SVH
// Notes on behaviour
// - Velocity feedforward gain scales command velocity
// - Acceleration feedforward added to servo output
// - No acceleration feedforward for velocity drives
// - Position error times proportional gain
// - Accumulated position error times integral gain
// - Integrators freeze while output saturated
// - Hold option freezes integrators during motion
// - Without hold, integrators run unless output saturated
// - Velocity gains used only for torque drives
// - Velocity error times velocity proportional gain
// - Velocity error accumulated, scaled, added
`define SPVL_GAIN_FRAC 16
`define SPVL_DW 32
`define SPVL_GW 24
`define SPVL_AW 48
`define SPVL_UPD_LAT 1
`endif

// [common/spvl_pkg.sv]
package spvl_pkg;
   typedef struct packed {
      logic [23:0] vel_ff;
      logic [23:0] acc_ff;
      logic [23:0] pos_p;
      logic [23:0] pos_i;
      logic [23:0] vel_p;
      logic [23:0] vel_i;
   } spvl_gains_t;
   typedef struct packed {
      logic signed [31:0] pos_err;
      logic signed [31:0] cmd_vel;
      logic signed [31:0] cmd_acc;
      logic signed [31:0] act_vel;
   } spvl_sample_t;
   typedef enum logic [1:0] {
      SPVL_IDLE = 2'b00,
      SPVL_POS = 2'b01,
      SPVL_OUT = 2'b10
   } spvl_state_t;
endpackage

// [core/spvl_mac.sv]
`timescale 1ns/1ps
`include "spvl_defs.svh"
// Signed value times unsigned fixed-point gain, result saturated to output width
module spvl_mac #(
   parameter int DW = 32,
   parameter int GW = 24,
   parameter int FRAC = 16
) (
   input wire logic signed [DW+15:0] val_i,
   input wire logic [GW-1:0] gain_i,
   output logic signed [DW-1:0] prod_o
);
   localparam int PW = DW + 16 + GW + 1;
   wire logic signed [PW-1:0] full_w;
   wire logic signed [PW-1:0] shft_w;
   wire logic signed [DW-1:0] maxv_w;
   wire logic signed [DW-1:0] minv_w;
   assign full_w = PW'(val_i) * $signed({1'b0, gain_i});
   assign shft_w = full_w >>> FRAC;
   assign maxv_w = {1'b0, {(DW-1){1'b1}}};
   assign minv_w = {1'b1, {(DW-1){1'b0}}};
   assign prod_o = (shft_w > PW'(maxv_w)) ? maxv_w :
                   (shft_w < PW'(minv_w)) ? minv_w : shft_w[DW-1:0];
endmodule

// [core/spvl_loop.sv]
`timescale 1ns/1ps
`include "spvl_defs.svh"
module spvl_loop #(
   parameter int DW = `SPVL_DW,
   parameter int GW = `SPVL_GW,
   parameter int AW = `SPVL_AW
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic update_i,
   input wire spvl_pkg::spvl_sample_t sample_i,
   input wire spvl_pkg::spvl_gains_t gains_i,
   input wire logic torque_drive_i,
   input wire logic integ_hold_en_i,
   output logic signed [DW-1:0] vel_cmd_o,
   output logic signed [DW-1:0] servo_out_o,
   output logic saturated_o,
   output logic out_valid_o
);
   spvl_pkg::spvl_state_t state_q;
   spvl_pkg::spvl_state_t state_d;
   spvl_pkg::spvl_sample_t smp_q;
   logic signed [AW-1:0] pos_acc_q;
   logic signed [AW-1:0] vel_acc_q;
   logic signed [DW-1:0] vel_cmd_q;
   logic signed [DW-1:0] servo_q;
   logic sat_q;
   logic valid_q;
   logic signed [DW-1:0] prev_cmd_q;

   wire logic signed [DW-1:0] ff_v_w;
   wire logic signed [DW-1:0] pp_w;
   wire logic signed [DW-1:0] pi_w;
   wire logic signed [DW-1:0] vp_w;
   wire logic signed [DW-1:0] vi_w;
   wire logic signed [DW-1:0] af_w;
   wire logic signed [DW-1:0] vel_err_w;
   wire logic signed [DW+3:0] vsum_w;
   wire logic signed [DW+3:0] osum_w;
   wire logic signed [DW-1:0] vel_sat_w;
   wire logic signed [DW-1:0] out_sat_w;
   wire logic out_clip_w;
   wire logic moving_w;
   wire logic integ_run_w;
   wire logic signed [DW-1:0] maxv_w;
   wire logic signed [DW-1:0] minv_w;

   assign maxv_w = {1'b0, {(DW-1){1'b1}}};
   assign minv_w = {1'b1, {(DW-1){1'b0}}};

   // Each gain stage is the same saturating multiplier
   spvl_mac #(.DW(DW), .GW(GW), .FRAC(`SPVL_GAIN_FRAC)) u_vff (
      .val_i((DW+16)'(smp_q.cmd_vel)), .gain_i(gains_i.vel_ff), .prod_o(ff_v_w));
   spvl_mac #(.DW(DW), .GW(GW), .FRAC(`SPVL_GAIN_FRAC)) u_pp (
      .val_i((DW+16)'(smp_q.pos_err)), .gain_i(gains_i.pos_p), .prod_o(pp_w));
   spvl_mac #(.DW(DW), .GW(GW), .FRAC(`SPVL_GAIN_FRAC)) u_pi (
      .val_i(pos_acc_q), .gain_i(gains_i.pos_i), .prod_o(pi_w));
   spvl_mac #(.DW(DW), .GW(GW), .FRAC(`SPVL_GAIN_FRAC)) u_vp (
      .val_i((DW+16)'(vel_err_w)), .gain_i(gains_i.vel_p), .prod_o(vp_w));
   spvl_mac #(.DW(DW), .GW(GW), .FRAC(`SPVL_GAIN_FRAC)) u_vi (
      .val_i(vel_acc_q), .gain_i(gains_i.vel_i), .prod_o(vi_w));
   spvl_mac #(.DW(DW), .GW(GW), .FRAC(`SPVL_GAIN_FRAC)) u_aff (
      .val_i((DW+16)'(smp_q.cmd_acc)), .gain_i(gains_i.acc_ff), .prod_o(af_w));

   // Velocity command: feedforward plus position P and I
   assign vsum_w = (DW+4)'(ff_v_w) + (DW+4)'(pp_w) + (DW+4)'(pi_w);
   assign vel_sat_w = (vsum_w > (DW+4)'(maxv_w)) ? maxv_w :
                      (vsum_w < (DW+4)'(minv_w)) ? minv_w : vsum_w[DW-1:0];
   assign vel_err_w = DW'(vel_cmd_q - smp_q.act_vel);
   // Torque drive: inner velocity loop plus acceleration feedforward
   assign osum_w = torque_drive_i ?
      ((DW+4)'(vp_w) + (DW+4)'(vi_w) + (DW+4)'(af_w)) :
      (DW+4)'(vel_cmd_q);
   assign out_clip_w = (osum_w > (DW+4)'(maxv_w)) || (osum_w < (DW+4)'(minv_w));
   assign out_sat_w = (osum_w > (DW+4)'(maxv_w)) ? maxv_w :
                      (osum_w < (DW+4)'(minv_w)) ? minv_w : osum_w[DW-1:0];
   // Command position changes whenever command velocity is nonzero
   assign moving_w = (smp_q.cmd_vel != '0) || (prev_cmd_q != smp_q.cmd_vel);
   assign integ_run_w = !sat_q && !(integ_hold_en_i && moving_w);

   always_comb
   begin
      state_d = state_q;
      case (state_q)
         spvl_pkg::SPVL_IDLE: if (update_i) state_d = spvl_pkg::SPVL_POS;
         spvl_pkg::SPVL_POS: state_d = spvl_pkg::SPVL_OUT;
         spvl_pkg::SPVL_OUT: state_d = spvl_pkg::SPVL_IDLE;
         default: state_d = spvl_pkg::SPVL_IDLE;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_q <= spvl_pkg::SPVL_IDLE;
         smp_q <= '0;
         prev_cmd_q <= '0;
         pos_acc_q <= '0;
         vel_acc_q <= '0;
         vel_cmd_q <= '0;
         servo_q <= '0;
         sat_q <= 1'b0;
         valid_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         valid_q <= 1'b0;
         if (state_q == spvl_pkg::SPVL_IDLE && update_i)
         begin
            smp_q <= sample_i;
            prev_cmd_q <= smp_q.cmd_vel;
         end
         if (state_q == spvl_pkg::SPVL_POS)
         begin
            vel_cmd_q <= vel_sat_w;
            if (integ_run_w)
               pos_acc_q <= pos_acc_q + AW'(smp_q.pos_err);
         end
         if (state_q == spvl_pkg::SPVL_OUT)
         begin
            servo_q <= out_sat_w;
            sat_q <= out_clip_w;
            valid_q <= 1'b1;
            if (integ_run_w && torque_drive_i)
               vel_acc_q <= vel_acc_q + AW'(vel_err_w);
         end
      end
   end

   assign vel_cmd_o = vel_cmd_q;
   assign servo_out_o = servo_q;
   assign saturated_o = sat_q;
   assign out_valid_o = valid_q;

   chk_pos_integ_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_q == spvl_pkg::SPVL_POS && (sat_q || (integ_hold_en_i && moving_w)))
      |=> $stable(pos_acc_q)) else $error("position integrator ran while held");
   chk_pos_integ_run: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_q == spvl_pkg::SPVL_POS && !sat_q && !integ_hold_en_i)
      |=> pos_acc_q == $past(pos_acc_q) + AW'($past(smp_q.pos_err)))
      else $error("position integrator stalled without hold");
   chk_vel_unused: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_q == spvl_pkg::SPVL_OUT && !torque_drive_i) |=> servo_out_o == $past(vel_cmd_q))
      else $error("velocity drive output not velocity command");
   chk_vel_integ_idle: assert property (@(posedge clk_i) disable iff (rst_i)
      !torque_drive_i |=> $stable(vel_acc_q))
      else $error("velocity integrator ran for velocity drive");
   sequence upd_seq;
      (state_q == spvl_pkg::SPVL_IDLE && update_i) ##1 (state_q == spvl_pkg::SPVL_POS);
   endsequence
   chk_update_once: assert property (@(posedge clk_i) disable iff (rst_i)
      upd_seq |-> ##1 (state_q == spvl_pkg::SPVL_OUT) ##1 out_valid_o)
      else $error("update did not finish in three cycles");
   chk_out_sat_flag: assert property (@(posedge clk_i) disable iff (rst_i)
      out_valid_o && saturated_o |-> (servo_out_o == maxv_w || servo_out_o == minv_w))
      else $error("saturation flag inconsistent");
   chk_vel_cmd_sum: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_q == spvl_pkg::SPVL_POS && !vsum_w[DW+3] && vsum_w <= (DW+4)'(maxv_w))
      |=> vel_cmd_o == $past(vsum_w[DW-1:0])) else $error("velocity command wrong");
   chk_torque_sum: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_q == spvl_pkg::SPVL_OUT && torque_drive_i && !out_clip_w)
      |=> servo_out_o == $past(DW'(vp_w + vi_w + af_w)))
      else $error("torque output wrong");
endmodule

// [verif/spvl_drive_model.sv]
`timescale 1ns/1ps
// Ideal drive: its actual velocity follows the last servo output it received
module spvl_drive_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic valid_i,
   input wire logic signed [31:0] cmd_i,
   output logic signed [31:0] act_vel_o
);
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         act_vel_o <= 32'h0;
      else if (valid_i)
         act_vel_o <= cmd_i;
   end
endmodule

// [verif/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic update_i = 1'b0;
   logic torque_drive_i = 1'b0;
   logic integ_hold_en_i = 1'b0;
   logic [31:0] pe = 32'h0;
   logic [31:0] cv = 32'h0;
   logic [31:0] ca = 32'h0;
   logic signed [31:0] act;
   logic signed [31:0] vel_cmd_o;
   logic signed [31:0] servo_out_o;
   logic saturated_o;
   logic out_valid_o;
   spvl_pkg::spvl_gains_t g = '0;
   spvl_pkg::spvl_sample_t s;
   int failures = 0;
   int checks_done = 0;
   assign s = {pe, cv, ca, act};
   initial forever #5 clk_i = ~clk_i;
   spvl_loop dut (.clk_i, .rst_i, .update_i, .sample_i(s), .gains_i(g), .torque_drive_i,
      .integ_hold_en_i, .vel_cmd_o, .servo_out_o, .saturated_o, .out_valid_o);
   spvl_drive_model drv (.clk_i, .rst_i, .valid_i(out_valid_o), .cmd_i(servo_out_o),
      .act_vel_o(act));
   task automatic close_out;
      if (failures == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] v);
      checks_done++;
      if (v !== e)
      begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", n, e, v);
      end
   endtask
   // Reset with new gains; integrators start from zero
   task automatic rst(input spvl_pkg::spvl_gains_t gv);
      @(posedge clk_i);
      rst_i <= 1'b1;
      g <= gv;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      #1;
      chk("vel_cmd_o", 32'h0, vel_cmd_o);
      chk("servo_out_o", 32'h0, servo_out_o);
   endtask
   // One servo update; returns once the new output has stood for its cycle
   task automatic run(input logic [31:0] p, v, a, input logic t, h);
      int n;
      @(posedge clk_i);
      pe <= p;
      cv <= v;
      ca <= a;
      torque_drive_i <= t;
      integ_hold_en_i <= h;
      update_i <= 1'b1;
      @(posedge clk_i);
      update_i <= 1'b0;
      #1;
      for (n = 1; n < 20 && out_valid_o !== 1'b1; n++)
         @(posedge clk_i) #1;
      if (n == 20)
      begin
         failures++;
         close_out();
      end
      chk("latency", 32'h3, n);
      @(posedge clk_i) #1;
      chk("out_valid_o", 32'h0, {31'h0, out_valid_o});
   endtask
   initial
   begin
      rst({24'h010000, 24'h030000, 24'h020000, 24'h0, 24'h020000, 24'h010000});
      run(32'hA, 32'h64, 32'h7, 1'b0, 1'b0);
      chk("vel_cmd_o", 32'h78, vel_cmd_o);
      chk("servo_out_o", 32'h78, servo_out_o);
      chk("saturated_o", 32'h0, {31'h0, saturated_o});
      rst({24'h010000, 24'h030000, 24'h020000, 24'h010000, 24'h020000, 24'h010000});
      run(32'h14, 32'h64, 32'h7, 1'b1, 1'b0);
      chk("vel_cmd_o", 32'h8C, vel_cmd_o);
      chk("servo_out_o", 32'h12D, servo_out_o);
      run(32'h14, 32'h64, 32'h7, 1'b1, 1'b0);
      chk("vel_cmd_o", 32'hA0, vel_cmd_o);
      chk("servo_out_o", 32'hFFFFFF87, servo_out_o);
      rst({24'h010000, 24'h030000, 24'h020000, 24'h010000, 24'h020000, 24'h010000});
      run(32'h14, 32'h64, 32'h7, 1'b1, 1'b1);
      chk("vel_cmd_o", 32'h8C, vel_cmd_o);
      chk("servo_out_o", 32'h12D, servo_out_o);
      run(32'h14, 32'h64, 32'h7, 1'b1, 1'b1);
      chk("vel_cmd_o", 32'h8C, vel_cmd_o);
      chk("servo_out_o", 32'hFFFFFED3, servo_out_o);
      rst({24'h010000, 24'h010000, 24'h0, 24'h010000, 24'h010000, 24'h010000});
      run(32'h0, 32'h40000000, 32'h40000000, 1'b1, 1'b0);
      chk("vel_cmd_o", 32'h40000000, vel_cmd_o);
      chk("servo_out_o", 32'h7FFFFFFF, servo_out_o);
      chk("saturated_o", 32'h1, {31'h0, saturated_o});
      run(32'h5, 32'h0, 32'h0, 1'b1, 1'b0);
      chk("vel_cmd_o", 32'h0, vel_cmd_o);
      chk("servo_out_o", 32'hC0000001, servo_out_o);
      chk("saturated_o", 32'h0, {31'h0, saturated_o});
      run(32'h0, 32'h0, 32'h0, 1'b1, 1'b0);
      chk("vel_cmd_o", 32'h0, vel_cmd_o);
      chk("servo_out_o", 32'h7FFFFFFF, servo_out_o);
      close_out();
   end
endmodule
